/* File: common/svt_pkg.sv */
// constants and carrier types for the vertical timing and serial output control block
// assumes a single 100 MHz clock domain shared with the parallel pixel source
package svt_pkg;
    localparam int unsigned WORD_W      = 20;
    localparam int unsigned BIT_CNT_W   = 5;
    localparam int unsigned DIV_W       = 4;
    localparam int unsigned ADDR_W      = 4;
    // register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_ADDR   = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;
    localparam logic [ADDR_W-1:0] FRAMES_ADDR = 4'h8;
    // control fields
    localparam int unsigned CTRL_SOFT_STANDBY = 0;
    localparam int unsigned CTRL_FORCE_OFF    = 1;
    localparam logic [1:0]  CTRL_RESET        = 2'h0;
    // status fields
    localparam int unsigned ST_VFLAG    = 0;
    localparam int unsigned ST_DISPLAY  = 1;
    localparam int unsigned ST_EMBEDDED = 2;
    localparam int unsigned ST_STANDBY  = 3;
    localparam int unsigned ST_OE       = 4;
    localparam int unsigned ST_RATE_LO  = 5;
    localparam int unsigned ST_BUF_LO   = 7;
    // embedded sync word detection on the low ten bits
    localparam logic [9:0] TRS_ONES  = 10'h3ff;
    localparam logic [9:0] TRS_ZEROS = 10'h000;
    localparam int unsigned TRS_V_BIT = 7;
    // clock cycles per serial bit for each line rate
    localparam logic [DIV_W-1:0] DIV_3G = 4'h1;
    localparam logic [DIV_W-1:0] DIV_HD = 4'h2;
    localparam logic [DIV_W-1:0] DIV_SD = 4'hb;
    // line rate codes, as seen on the status register
    localparam logic [1:0] RATE_HD = 2'h0;
    localparam logic [1:0] RATE_3G = 2'h1;
    localparam logic [1:0] RATE_SD = 2'h2;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic              vflag;
    } svt_pix_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
    } svt_avs_req_t;

    typedef struct packed {
        logic p;
        logic n;
        logic oe;
    } svt_serial_t;

    typedef enum logic [1:0] {
        SVT_IDLE    = 2'b00,
        SVT_SHIFT   = 2'b01,
        SVT_STANDBY = 2'b10
    } svt_state_t;
endpackage

/* File: dv/svt_src_model.sv */
// upstream parallel video source: offers one word at a time on valid/ready
// assumes the bench calls send from its own sequence, right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module svt_src_model
    import svt_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              ready_in,
    output logic [WORD_W-1:0]      data_out,
    output logic                   valid_out,
    output logic                   vtiming_out
);
    // words that were never taken before the limit ran out; the bench judges it
    int stalls = 0;

    initial begin
        data_out    = '0;
        valid_out   = 1'b0;
        vtiming_out = 1'b0;
    end

    // the vertical level is held per line, so it is left standing after a word
    task automatic send(input logic [WORD_W-1:0] w, input logic v);
        int n;
        n = 0;
        @(posedge clock_in);
        data_out    <= w;
        vtiming_out <= v;
        valid_out   <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
        end while (ready_in !== 1'b1 && n < 2000);
        if (ready_in !== 1'b1) begin
            stalls++;
        end
        valid_out <= 1'b0;
        // released bus shows the inverse so a stale word cannot pass for a new one
        data_out  <= ~w;
    endtask
endmodule // svt_src_model
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the vertical timing and serial output control block
// assumes the source model owns the pixel port and the bench is the bus master
`timescale 1ns/1ps
`default_nettype none
module tb;
    import svt_pkg::*;
    logic              clock_in = 1'b0;
    logic              reset_n_in = 1'b0;
    svt_avs_req_t      req = '0;
    logic              waitreq;
    logic [31:0]       rdata;
    logic [WORD_W-1:0] pdata;
    logic              pvalid, pready, vt, vflag, stby_act, saw;
    logic              disp = 1'b0, emb = 1'b0, stby = 1'b0, oe_en = 1'b1;
    logic [1:0]        rs = 2'h0;
    svt_serial_t       ser;
    int                err_count = 0;
    int                checked = 0;

    svt_vtiming_ctl DUT (.clock_in(clock_in), .reset_n_in(reset_n_in), .avs_req_in(req),
        .avs_waitrequest_out(waitreq), .avs_readdata_out(rdata), .pix_data_in(pdata),
        .pix_valid_in(pvalid), .pix_ready_out(pready), .vtiming_in(vt),
        .display_timing_select_in(disp), .embedded_sync_detect_in(emb), .standby_in(stby),
        .serial_out_enable_in(oe_en), .rate_select_0_in(rs[0]), .rate_select_1_in(rs[1]),
        .serial_out_pair_out(ser), .vflag_out(vflag), .standby_active_out(stby_act));
    svt_src_model src (.clock_in(clock_in), .ready_in(pready), .data_out(pdata),
        .valid_out(pvalid), .vtiming_out(vt));

    initial forever #5 clock_in = ~clock_in;
    initial saw = 1'b0;
    always @(posedge clock_in) if (vflag === 1'b1) saw <= 1'b1;

    task automatic end_of_test;
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clock_in);
        req <= '{address: a, read: ~wr, write: wr, writedata: wd};
        do begin
            @(posedge clock_in);
            n++;
        end while (waitreq !== 1'b0 && n < 100);
        if (waitreq !== 1'b0) begin
            err_count++;
        end
        rd = rdata;
        req <= '0;
    endtask

    task automatic t_output;
        logic [31:0] d;
        bus(0, CTRL_ADDR, 32'h0, d);
        check(d, 32'h0);
        bus(0, 4'hc, 32'h0, d);
        check(d, 32'h0);
        oe_en <= 1'b0;
        repeat (3) @(posedge clock_in);
        check(ser.oe, 1'b0);
        oe_en <= 1'b1;
        repeat (3) @(posedge clock_in);
        check(ser.oe, 1'b1);
        bus(1, CTRL_ADDR, 32'h2, d);
        bus(0, CTRL_ADDR, 32'h0, d);
        check(d, 32'h2);
        repeat (2) @(posedge clock_in);
        check(ser.oe, 1'b0);
        bus(1, CTRL_ADDR, 32'h0, d);
    endtask

    task automatic t_standby;
        logic [31:0] d;
        int n;
        stby <= 1'b1;
        for (n = 0; n < 50 && stby_act !== 1'b1; n++) @(posedge clock_in);
        @(posedge clock_in);
        check({stby_act, pready, ser.oe}, 3'b100);
        stby <= 1'b0;
        for (n = 0; n < 50 && stby_act !== 1'b0; n++) @(posedge clock_in);
        check({stby_act, pready}, 2'b01);
        // software standby through the control register takes the same path as the pin
        bus(1, CTRL_ADDR, 32'h1, d);
        for (n = 0; n < 50 && stby_act !== 1'b1; n++) @(posedge clock_in);
        check(stby_act, 1'b1);
        bus(1, CTRL_ADDR, 32'h0, d);
        for (n = 0; n < 50 && stby_act !== 1'b0; n++) @(posedge clock_in);
        check(stby_act, 1'b0);
    endtask

    // rising edges of the selected flag: one each in the blanking, sync and embedded runs
    task automatic t_frames;
        logic [31:0] d;
        bus(0, FRAMES_ADDR, 32'h0, d);
        check(d, 32'h3);
        check(src.stalls, 32'h0);
    endtask

    // a sync-word group is sent so the embedded path has something to decode
    task automatic t_vflag(input logic d, input logic e, input logic v, input logic b7,
                           input logic exp);
        @(posedge clock_in);
        disp <= d;
        emb  <= e;
        rs   <= 2'b10;
        src.send(20'h00000, 1'b0);
        repeat (50) @(posedge clock_in);
        saw <= 1'b0;
        src.send(20'h003ff, v);
        src.send(20'h00000, v);
        src.send(20'h00000, v);
        src.send({12'h0, b7, 7'h0}, v);
        // the decoded flag applies from the word after the sync group
        src.send(20'h00000, v);
        repeat (100) @(posedge clock_in);
        check(saw, exp);
    endtask

    task automatic t_rate(input logic [1:0] r, input logic [DIV_W-1:0] div,
                          input logic [1:0] code);
        logic [31:0] d;
        int          n;
        int          cnt;
        @(posedge clock_in);
        rs <= r;
        repeat (2) @(posedge clock_in);
        bus(0, STATUS_ADDR, 32'h0, d);
        check(d[ST_RATE_LO +: 2], code);
        src.send(20'h55555, 1'b0);
        for (n = 0; n < 50 && ser.p !== 1'b1; n++) @(posedge clock_in);
        cnt = 0;
        while (ser.p === 1'b1 && cnt < 40) begin
            @(posedge clock_in);
            cnt++;
        end
        check(cnt, div);
        check(ser.n, {~ser.p});
        src.send(20'h0aaaa, 1'b0);
        src.send(20'h00f0f, 1'b0);
        @(posedge clock_in);
        check(pready, 1'b0);
        for (n = 0; n < 1000 && pready !== 1'b1; n++) @(posedge clock_in);
        check(pready, 1'b1);
        repeat (600) @(posedge clock_in);
    endtask

    initial begin
        #400000;
        err_count++;
        end_of_test;
    end

    initial begin
        repeat (16) @(posedge clock_in);
        reset_n_in <= 1'b1;
        @(posedge clock_in);
        t_output;
        t_standby;
        t_vflag(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        t_vflag(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        t_vflag(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        t_vflag(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        t_vflag(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        t_rate(2'b00, DIV_HD, RATE_HD);
        t_rate(2'b10, DIV_3G, RATE_3G);
        t_rate(2'b11, DIV_SD, RATE_SD);
        t_frames;
        end_of_test;
    end
endmodule // tb
`default_nettype wire

/* File: verilog/svt_vtiming_ctl.sv */
// vertical timing interpretation, two-entry word buffer, serializer and output control
// assumes pixel inputs change in step with clock_in and an Avalon-MM master on the bus
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module svt_vtiming_ctl
(
    input  wire logic              clock_in,
    input  wire logic              reset_n_in,
    input  wire svt_pkg::svt_avs_req_t avs_req_in,
    output logic                   avs_waitrequest_out,
    output logic [31:0]            avs_readdata_out,
    input  wire logic [svt_pkg::WORD_W-1:0] pix_data_in,
    input  wire logic              pix_valid_in,
    output logic                   pix_ready_out,
    input  wire logic              vtiming_in,
    input  wire logic              display_timing_select_in,
    input  wire logic              embedded_sync_detect_in,
    input  wire logic              standby_in,
    input  wire logic              serial_out_enable_in,
    input  wire logic              rate_select_0_in,
    input  wire logic              rate_select_1_in,
    output svt_pkg::svt_serial_t   serial_out_pair_out,
    output logic                   vflag_out,
    output logic                   standby_active_out
);
    import svt_pkg::*;

    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdata;
        logic [1:0]           ctrl;
        logic [15:0]          frames;
        logic                 v_prev;
        logic [1:0]           trs_cnt;
        logic                 emb_v;
        svt_pix_t [1:0]       fifo;
        logic                 wr_ptr;
        logic                 rd_ptr;
        logic [1:0]           count;
        logic [WORD_W-1:0]    shreg;
        logic                 cur_v;
        logic [BIT_CNT_W-1:0] bit_cnt;
        logic [DIV_W-1:0]     div_cnt;
        logic                 oe;
        svt_state_t           state;
    } svt_regs_t;

    svt_regs_t r;
    svt_regs_t next_r;

    function automatic logic [DIV_W-1:0] rate_div(input logic s0, input logic s1);
        if (s0) begin
            return DIV_SD;
        end else if (s1) begin
            return DIV_3G;
        end
        return DIV_HD;
    endfunction

    function automatic logic [1:0] rate_code(input logic s0, input logic s1);
        if (s0) begin
            return RATE_SD;
        end else if (s1) begin
            return RATE_3G;
        end
        return RATE_HD;
    endfunction

    logic              stby;
    logic              push;
    logic              pop;
    logic              vsel;
    logic [DIV_W-1:0]  div_lim;
    logic [31:0]       status;
    logic              last_bit;

    assign stby    = standby_in | r.ctrl[CTRL_SOFT_STANDBY];
    assign div_lim = rate_div(rate_select_0_in, rate_select_1_in);
    assign pix_ready_out = (r.count != 2'h2) && (r.state != SVT_STANDBY);
    assign push    = pix_valid_in && pix_ready_out;
    assign last_bit = (r.div_cnt == div_lim - 4'h1) && (r.bit_cnt == BIT_CNT_W'(WORD_W - 1));
    assign pop     = (r.count != 2'h0) && ((r.state == SVT_IDLE) ||
                     ((r.state == SVT_SHIFT) && last_bit));

    // pin only counts when no embedded sync; both pin readings share one path
    always_comb begin
        if (embedded_sync_detect_in) begin
            vsel = r.emb_v;
        end else if (display_timing_select_in) begin
            vsel = vtiming_in;
        end else begin
            vsel = vtiming_in;
        end
    end

    always_comb begin
        status = 32'h0;
        status[ST_VFLAG]    = vsel;
        status[ST_DISPLAY]  = display_timing_select_in;
        status[ST_EMBEDDED] = embedded_sync_detect_in;
        status[ST_STANDBY]  = r.state == SVT_STANDBY;
        status[ST_OE]       = r.oe;
        status[ST_RATE_LO +: 2] = rate_code(rate_select_0_in, rate_select_1_in);
        status[ST_BUF_LO +: 2]  = r.count;
    end

    assign avs_waitrequest_out = (avs_req_in.read || avs_req_in.write) && !r.ack;
    assign avs_readdata_out    = r.rdata;
    assign serial_out_pair_out.p  = r.shreg[0];
    assign serial_out_pair_out.n  = ~r.shreg[0];
    assign serial_out_pair_out.oe = r.oe;
    assign vflag_out          = r.cur_v;
    assign standby_active_out = r.state == SVT_STANDBY;

    always_comb begin
        next_r = r;
        // one wait cycle per access; ack drops so back-to-back requests each wait
        next_r.ack = (avs_req_in.read || avs_req_in.write) && !r.ack;
        if (avs_req_in.read && !r.ack) begin
            case (avs_req_in.address)
                CTRL_ADDR:   next_r.rdata = {30'h0, r.ctrl};
                STATUS_ADDR: next_r.rdata = status;
                FRAMES_ADDR: next_r.rdata = {16'h0, r.frames};
                default:     next_r.rdata = 32'h0;
            endcase
        end
        if (avs_req_in.write && !r.ack && avs_req_in.address == CTRL_ADDR) begin
            next_r.ctrl = avs_req_in.writedata[1:0];
        end
        next_r.oe = serial_out_enable_in && !stby && !r.ctrl[CTRL_FORCE_OFF];

        if (push) begin
            // embedded sync words carry the vertical bit in the fourth word
            case (r.trs_cnt)
                2'h0: next_r.trs_cnt = (pix_data_in[9:0] == TRS_ONES) ? 2'h1 : 2'h0;
                2'h1, 2'h2: begin
                    if (pix_data_in[9:0] == TRS_ZEROS) begin
                        next_r.trs_cnt = r.trs_cnt + 2'h1;
                    end else begin
                        next_r.trs_cnt = (pix_data_in[9:0] == TRS_ONES) ? 2'h1 : 2'h0;
                    end
                end
                default: begin
                    next_r.trs_cnt = 2'h0;
                    next_r.emb_v   = pix_data_in[TRS_V_BIT];
                end
            endcase
            next_r.v_prev = vsel;
            if (vsel && !r.v_prev) begin
                next_r.frames = r.frames + 16'h1;
            end
            next_r.fifo[r.wr_ptr] = '{data: pix_data_in, vflag: vsel};
            next_r.wr_ptr = ~r.wr_ptr;
        end
        if (pop) begin
            next_r.rd_ptr  = ~r.rd_ptr;
            next_r.shreg   = r.fifo[r.rd_ptr].data;
            next_r.cur_v   = r.fifo[r.rd_ptr].vflag;
            next_r.bit_cnt = '0;
            next_r.div_cnt = '0;
        end
        next_r.count = r.count + {1'b0, push} - {1'b0, pop};

        case (r.state)
            SVT_IDLE: begin
                if (stby) begin
                    next_r.state = SVT_STANDBY;
                end else if (pop) begin
                    next_r.state = SVT_SHIFT;
                end
            end
            SVT_SHIFT: begin
                if (!pop) begin
                    if (r.div_cnt == div_lim - 4'h1) begin
                        next_r.div_cnt = '0;
                        next_r.shreg   = {1'b0, r.shreg[WORD_W-1:1]};
                        next_r.bit_cnt = r.bit_cnt + 5'h1;
                        if (last_bit) begin
                            next_r.state = stby ? SVT_STANDBY : SVT_IDLE;
                        end
                    end else begin
                        next_r.div_cnt = r.div_cnt + 4'h1;
                    end
                end
            end
            SVT_STANDBY: begin
                if (!stby) begin
                    next_r.state = SVT_IDLE;
                end
            end
            default: next_r.state = SVT_IDLE;
        endcase
        // standby drops buffered words and idles the shifter to save power
        if (next_r.state == SVT_STANDBY) begin
            next_r.count  = 2'h0;
            next_r.wr_ptr = 1'b0;
            next_r.rd_ptr = 1'b0;
            next_r.shreg  = '0;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            r       <= '0;
            r.ctrl  <= CTRL_RESET;
            r.state <= SVT_IDLE;
        end else begin
            r <= next_r;
        end
    end

    blank_flag_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (push && !display_timing_select_in && !embedded_sync_detect_in)
        |=> r.fifo[$past(r.wr_ptr)].vflag == $past(vtiming_in))
        else $error("blanking flag not taken from the vertical pin");
    embedded_ignore_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (push && embedded_sync_detect_in && !display_timing_select_in)
        |=> r.fifo[$past(r.wr_ptr)].vflag == $past(r.emb_v))
        else $error("vertical pin used while embedded sync active");
    vsync_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (push && display_timing_select_in && !embedded_sync_detect_in && vtiming_in)
        |=> r.fifo[$past(r.wr_ptr)].vflag)
        else $error("vertical sync not captured");
    vsync_ignore_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (display_timing_select_in && embedded_sync_detect_in) |-> status[ST_VFLAG] == r.emb_v)
        else $error("vertical sync not ignored");
    standby_enter_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (standby_in && r.state == SVT_IDLE) |=> standby_active_out && !pix_ready_out)
        else $error("standby not entered");
    output_float_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !serial_out_enable_in |=> !serial_out_pair_out.oe)
        else $error("serial output driven while disabled");
    output_drive_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (serial_out_enable_in && !stby && !r.ctrl[CTRL_FORCE_OFF]) |=> serial_out_pair_out.oe)
        else $error("serial output not driven while enabled");
    rate_step_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (r.state == SVT_SHIFT && !pop && r.div_cnt != div_lim - 4'h1 && $stable(div_lim))
        |=> $stable(r.shreg))
        else $error("bit shifted before its rate period ended");
    sample_step_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        push |=> r.count == $past(r.count) + 2'h1 - {1'b0, $past(pop)}
                 || r.state == SVT_STANDBY)
        else $error("accepted word not buffered");
endmodule // svt_vtiming_ctl
`default_nettype wire
